// file: logic/ptcap_cfg.svh
/*
  Offsets, field positions and reset values of the capture timer.
  Assumes byte addresses on an AXI4-Lite bus, one 32-bit word each.
*/
`ifndef PTCAP_CFG_SVH
`define PTCAP_CFG_SVH
`define CTRL_OFS     8'h00
`define PERIOD_OFS   8'h04
`define CAPA_OFS     8'h08
`define CAPB_OFS     8'h0C
`define COUNT_OFS    8'h10
`define STATUS_OFS   8'h14
`define CTRL_RUN     0
`define CTRL_MODE    1
`define CTRL_EDGE    3
`define CTRL_CLR     5
`define CTRL_SRC     7
`define CTRL_HALL    8
`define CTRL_CKSRC   9
`define CTRL_W       13
`define CTRL_RESET   13'h0000
`define MODE_CAPTURE 2'h1
`define ST_FLAG_A    0
`define ST_FLAG_P    1
`define ST_LEVEL     2
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// file: logic/ptcap_pkg.sv
/*
  Types of the capture timer: edge and clear-condition codes.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package ptcap_pkg;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_NONE} edge_mode_t;
  typedef enum logic [1:0] {CLR_PERIOD, CLR_RISE, CLR_FALL, CLR_BOTH} clear_cond_t;
endpackage : ptcap_pkg
`default_nettype wire

// file: logic/periodic_timer_capture_input.sv
/*
  Capture input mode of a periodic timer with an AXI4-Lite register port.
  Assumes capture pins are asynchronous and software keeps to its side.
*/
// Contract
// R1: software selects capture mode with code 01
// R2: run rising edge restarts counter from zero
// R3: active edge copies counter, raises interrupt
// R4: counter runs freely until run falls
// R5: period match clears counter, raises interrupt
// R6: zero period lets counter wrap at maximum
// R7: edge select picks rising, falling or both
// R8: edge select 11 disables capture, counter runs
// R9: source is capture pin, clock pin, hall
// R10: timer 0 clear select adds edge clears
// R11: timer 0 register choice uses both fields
// R12: edge and clear selects are independent
// R13: clear select 00 uses first register only
// R14: flag and level update half period later
// R15: timers 1-3 capture into first register only
// R16: latch within one and half timer clocks
// R17: pulses under two timer clocks may be lost
// R18: software avoids clock pin as both roles
// R19: no output; output bits have no effect
// R20: software needs an available counter clock
// R21: hall source is noise-filtered input pin
// R22: edge codes 00 rise, 01 fall, 10 both
// R23: rising to first, falling to second register
`include "ptcap_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module periodic_timer_capture_input
  import ptcap_pkg::*;
#(
  parameter int WIDTH      = 16,
  parameter int TICK_DIV   = 8,
  parameter int FILT_LEN   = 4,
  parameter bit TIMER_ZERO = 1'b1
)
(
  // system
  input  wire logic        clk,
  input  wire logic        reset,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // capture pins
  input  wire logic        dedicated_capture_pin,
  input  wire logic        timer_clock_pin,
  input  wire logic        noise_filter_input_pin,
  // timer side
  output logic             timer_out,
  output logic             timer_out_enable_n,
  output logic             timer_event
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [`CTRL_W-1:0] ctrl;
    logic [WIDTH-1:0]   period;
    logic [WIDTH-1:0]   cap_a;
    logic [WIDTH-1:0]   cap_b;
    logic [WIDTH-1:0]   count;
    logic               run_d;
    logic               flag_a;
    logic               flag_p;
    logic               level;
    logic               half_pend;
    logic               level_pend;
    logic [7:0]         pre;
    logic               src_s1;
    logic               src_s2;
    logic               ck_s1;
    logic               ck_s2;
    logic               ck_d;
    logic               nf_s1;
    logic               nf_s2;
    logic [7:0]         nf_cnt;
    logic               nf_out;
    logic               src_prev;
    logic               aw_got;
    logic [7:0]         aw_addr;
    logic               w_got;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic               event_p;
  } state_t;

  state_t s;
  state_t next_s;

  localparam logic [7:0] PRE_LAST  = 8'(TICK_DIV - 1);
  localparam logic [7:0] PRE_HALF  = 8'(TICK_DIV / 2 - 1);
  localparam logic [7:0] FILT_LAST = 8'(FILT_LEN - 1);
  // samples from a latch to the visible compare flag on the prescaler clock
  localparam int         HALF_WAIT = TICK_DIV / 2 + 1;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
      begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------
  // timer clock and capture edges
  // ----------------------------------------
  logic        mode_on;
  logic        running;
  logic        run_rise;
  logic        ck_from_pin;
  logic        tick;
  logic        half;
  logic        src;
  logic        rise_hit;
  logic        fall_hit;
  logic        cap_fire;
  logic        to_b;
  logic        clr_edge;
  logic        per_hit;
  edge_mode_t  edge_sel;
  clear_cond_t clr_sel;
  logic [31:0] merged_ctrl;
  logic [31:0] merged_period;
  logic [31:0] clear_mask;

  assign mode_on     = s.ctrl[`CTRL_MODE +: 2] == `MODE_CAPTURE;  // see R1
  assign running     = s.ctrl[`CTRL_RUN] & mode_on;
  assign run_rise    = running & ~s.run_d;
  assign ck_from_pin = s.ctrl[`CTRL_CKSRC];
  // a pin-driven timer clock has its half period marked by its falling edge
  assign tick        = ck_from_pin ? (s.ck_s2 & ~s.ck_d) : (s.pre == PRE_LAST);
  assign half        = ck_from_pin ? (~s.ck_s2 & s.ck_d) : (s.pre == PRE_HALF);
  assign src         = (TIMER_ZERO && s.ctrl[`CTRL_HALL]) ? s.nf_out :   // see R9, R21
                       s.ctrl[`CTRL_SRC] ? s.ck_s2 : s.src_s2;
  // sampled once per timer clock: narrow pulses can slip through
  assign rise_hit    = running & s.run_d & tick & src & ~s.src_prev;  // see R16, R17
  assign fall_hit    = running & s.run_d & tick & ~src & s.src_prev;
  assign edge_sel    = edge_mode_t'(s.ctrl[`CTRL_EDGE +: 2]);
  assign clr_sel     = clear_cond_t'(s.ctrl[`CTRL_CLR +: 2]);
  assign cap_fire    = (rise_hit & (edge_sel == EDGE_RISE || edge_sel == EDGE_BOTH)) |
                       (fall_hit & (edge_sel == EDGE_FALL || edge_sel == EDGE_BOTH));  // see R7, R8, R22
  assign to_b        = TIMER_ZERO && clr_sel != CLR_PERIOD && fall_hit;  // see R11, R13, R15, R23
  // clear select does not look at edge select at all
  assign clr_edge    = TIMER_ZERO && ((clr_sel[0] && rise_hit) || (clr_sel[1] && fall_hit));  // see R10, R12
  assign per_hit     = running & s.run_d & tick & (s.period != '0) & (s.count == s.period);
  // byte-lane merge of the held write word into each writable register
  assign merged_ctrl   = merge(32'(s.ctrl), s.w_data, s.w_strb);
  assign merged_period = merge(32'(s.period), s.w_data, s.w_strb);
  assign clear_mask    = merge(32'h0, s.w_data, s.w_strb);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_s         = s;
    next_s.event_p = 1'b0;
    next_s.src_s1  = dedicated_capture_pin;
    next_s.src_s2  = s.src_s1;
    next_s.ck_s1   = timer_clock_pin;
    next_s.ck_s2   = s.ck_s1;
    next_s.ck_d    = s.ck_s2;
    next_s.nf_s1   = noise_filter_input_pin;
    next_s.nf_s2   = s.nf_s1;
    next_s.run_d   = running;
    next_s.pre     = (s.pre == PRE_LAST) ? 8'h00 : s.pre + 8'h01;

    // hall filter: level must hold for FILT_LEN samples
    if (s.nf_s2 == s.nf_out)
    begin
      next_s.nf_cnt = 8'h00;
    end
    else if (s.nf_cnt == FILT_LAST)
    begin
      next_s.nf_out = s.nf_s2;  // see R21
      next_s.nf_cnt = 8'h00;
    end
    else
    begin
      next_s.nf_cnt = s.nf_cnt + 8'h01;
    end

    // bus write: address and data in either order
    if (awvalid && awready)
    begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_s.w_got  = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.bvalid && bready)
    begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = `RESP_OKAY;
      case (s.aw_addr)
        `CTRL_OFS:
          next_s.ctrl = merged_ctrl[`CTRL_W-1:0];
        `PERIOD_OFS:
          next_s.period = merged_period[WIDTH-1:0];
        `STATUS_OFS:
        begin
          // write one to clear; a same-cycle set below wins
          next_s.flag_a = s.flag_a & ~clear_mask[`ST_FLAG_A];
          next_s.flag_p = s.flag_p & ~clear_mask[`ST_FLAG_P];
        end
        `CAPA_OFS, `CAPB_OFS, `COUNT_OFS: ;
        default:
          next_s.bresp = `RESP_SLVERR;
      endcase
    end

    // bus read
    if (s.rvalid && rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = `RESP_OKAY;
      case (araddr)
        `CTRL_OFS:   next_s.rdata = 32'(s.ctrl);
        `PERIOD_OFS: next_s.rdata = 32'(s.period);
        `CAPA_OFS:   next_s.rdata = 32'(s.cap_a);
        `CAPB_OFS:   next_s.rdata = 32'(s.cap_b);
        `COUNT_OFS:  next_s.rdata = 32'(s.count);
        `STATUS_OFS: next_s.rdata = 32'({s.level, s.flag_p, s.flag_a});
        default:
        begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = `RESP_SLVERR;
        end
      endcase
    end

    // counter
    if (run_rise)
    begin
      next_s.count    = '0;  // see R2
      next_s.src_prev = src;
    end
    else if (running && tick)
    begin
      next_s.src_prev = src;
      if (per_hit || clr_edge)
      begin
        next_s.count = '0;  // see R5, R10
      end
      else
      begin
        // zero period: plain wrap at all ones
        next_s.count = s.count + 1'b1;  // see R4, R6
      end
    end

    // capture: old count is copied even when the same tick clears it
    if (cap_fire)
    begin
      if (to_b)
      begin
        next_s.cap_b = s.count;  // see R3, R23
      end
      else
      begin
        next_s.cap_a = s.count;  // see R3, R13, R15
      end
      next_s.half_pend  = 1'b1;
      next_s.level_pend = rise_hit;
    end
    else if (half && s.half_pend)
    begin
      next_s.half_pend = 1'b0;
      next_s.flag_a    = 1'b1;  // see R14, R15
      next_s.level     = s.level_pend;
      next_s.event_p   = 1'b1;  // see R3
    end

    if (per_hit)
    begin
      next_s.flag_p  = 1'b1;  // see R5
      next_s.event_p = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s      <= '0;
      s.ctrl <= `CTRL_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign awready            = ~s.aw_got & ~s.bvalid;
  assign wready             = ~s.w_got & ~s.bvalid;
  assign bvalid             = s.bvalid;
  assign bresp              = s.bresp;
  assign arready            = ~s.rvalid;
  assign rvalid             = s.rvalid;
  assign rdata              = s.rdata;
  assign rresp              = s.rresp;
  assign timer_event        = s.event_p;
  // output pin is never driven in this mode
  assign timer_out          = 1'b0;  // see R19
  assign timer_out_enable_n = 1'b1;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  run_start_zero_a: assert property ($rose(running) |=> s.count == '0)  // see R2
    else $error("counter not zero after run rise");
  period_clear_a: assert property (per_hit |=> s.count == '0 && s.flag_p)  // see R5
    else $error("period match did not clear and flag");
  zero_period_wrap_a: assert property (running && s.run_d && tick && s.period == '0
      && !clr_edge |=> s.count == WIDTH'($past(s.count) + 1'b1))  // see R6
    else $error("counter did not advance with zero period");
  stop_hold_a: assert property (!s.ctrl[`CTRL_RUN] |=> $stable(s.count))  // see R4
    else $error("counter moved while stopped");
  capture_a_copy_a: assert property (cap_fire && !to_b |=> s.cap_a == $past(s.count))  // see R3
    else $error("first capture register missed count");
  edge_off_a: assert property (edge_sel == EDGE_NONE |-> !cap_fire)  // see R8
    else $error("capture with edges disabled");
  second_unused_a: assert property (cap_fire && clr_sel == CLR_PERIOD
      |=> $stable(s.cap_b))  // see R13
    else $error("second register written with clear select 00");
  flag_delay_a: assert property (cap_fire && !s.flag_a |=> !s.flag_a)  // see R14
    else $error("compare flag set at the latch itself");
  half_flag_a: assert property (cap_fire && !ck_from_pin |-> ##HALF_WAIT s.flag_a)  // see R14
    else $error("compare flag not set half a tick after capture");
  edge_clear_a: assert property (rise_hit && TIMER_ZERO && clr_sel == CLR_RISE
      |=> s.count == '0)  // see R10
    else $error("rising edge did not clear counter");

endmodule : periodic_timer_capture_input
`default_nettype wire

// file: tb/capture_source.sv
/*
  Model of the pins that feed the capture timer: dedicated capture pin,
  timer clock pin and the noise filter input pin.
  Assumes the bench calls drive right after a rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module capture_source
(
  // clock
  input  wire logic clk,
  // pins
  output wire logic dedicated_capture_pin,
  output wire logic timer_clock_pin,
  output wire logic noise_filter_input_pin
);
  // index 0 dedicated pin, 1 timer clock pin, 2 filter input
  logic [2:0] lvl = 3'h0;

  assign dedicated_capture_pin  = lvl[0];
  assign timer_clock_pin        = lvl[1];
  assign noise_filter_input_pin = lvl[2];

  // holds each level for hold clock cycles, as long as the caller asks
  task automatic drive(input int s, input logic val, input int hold);
    lvl[s] <= val;
    repeat (hold) @(posedge clk);
  endtask : drive
endmodule : capture_source
`default_nettype wire

// file: tb/tb.sv
/*
  Self-checking bench of the capture timer over AXI4-Lite.
  Assumes the design package, the offset header and capture_source.
*/
`include "ptcap_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk     = 1'b0;
  logic        reset   = 1'b1;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid;
  wire logic   pin_d, pin_c, pin_h, t_out, t_oe_n, t_ev;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  logic [31:0] v, c0;
  logic [1:0]  rr, wb;
  int          err_count = 0;
  int          n_compared = 0;
  int          events = 0;

  always #2.5 clk = ~clk;
  always @(posedge clk) if (t_ev === 1'b1) events <= events + 1;

  capture_source src (.clk(clk), .dedicated_capture_pin(pin_d),
    .timer_clock_pin(pin_c), .noise_filter_input_pin(pin_h));

  // short tick keeps the run brief
  periodic_timer_capture_input #(.TICK_DIV(2)) dut (
    .clk(clk), .reset(reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .dedicated_capture_pin(pin_d), .timer_clock_pin(pin_c),
    .noise_filter_input_pin(pin_h), .timer_out(t_out),
    .timer_out_enable_n(t_oe_n), .timer_event(t_ev));

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready && !ad) begin ad = 1'b1; awvalid <= 1'b0; end
      if (wready && !wd) begin wd = 1'b1; wvalid <= 1'b0; end
    end while (!(ad && wd && bvalid));
    wb = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ad;
    ad = 1'b0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready && !ad) begin ad = 1'b1; arvalid <= 1'b0; end
    end while (!(ad && rvalid));
    v = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  // run, capture mode code 01, edge, clear select, source
  function automatic logic [31:0] ctl(int e, int c, int s);
    return 32'h3 | (e << 3) | (c << 5) | (s << 7);
  endfunction : ctl

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(`CTRL_OFS);
    check(v, 32'h0);
    check({30'h0, rr}, {30'h0, `RESP_OKAY});
    rd(8'h18);
    check({30'h0, rr}, {30'h0, `RESP_SLVERR});
    wr(8'h18, 32'h0);
    check({30'h0, wb}, {30'h0, `RESP_SLVERR});
    wr(`PERIOD_OFS, 32'h0);
    check({30'h0, wb}, {30'h0, `RESP_OKAY});
    check({30'h0, t_out, t_oe_n}, 32'h1);
    $display("reset test done");
  endtask : t_reset

  task automatic t_sources;
    int e0;
    wr(`PERIOD_OFS, 32'h0);
    for (int s = 0; s < 3; s++)
    begin
      // counter stays on the prescaler while the clock pin is a source
      wr(`CTRL_OFS, ctl(0, 0, s));
      wr(`STATUS_OFS, 32'h3);
      rd(`COUNT_OFS);
      c0 = v;
      e0 = events;
      src.drive(s, 1'b1, 20);
      rd(`CAPA_OFS);
      check({31'h0, v >= c0 && v <= c0 + 32'd12}, 32'h1);
      rd(`STATUS_OFS);
      check(v & 32'h1, 32'h1);
      check({31'h0, events > e0}, 32'h1);
      wr(`STATUS_OFS, 32'h3);
      src.drive(s, 1'b0, 20);
      rd(`STATUS_OFS);
      check(v & 32'h1, 32'h0);
    end
    $display("source test done");
  endtask : t_sources

  task automatic t_edges;
    for (int e = 0; e < 4; e++)
    begin
      wr(`CTRL_OFS, ctl(e, 0, 0));
      wr(`STATUS_OFS, 32'h3);
      src.drive(0, 1'b1, 20);
      rd(`STATUS_OFS);
      check(v & 32'h1, {31'h0, e == 0 || e == 2});
      wr(`STATUS_OFS, 32'h3);
      rd(`COUNT_OFS);
      c0 = v;
      src.drive(0, 1'b0, 20);
      rd(`STATUS_OFS);
      check(v & 32'h1, {31'h0, e == 1 || e == 2});
      rd(`COUNT_OFS);
      check({31'h0, v > c0}, 32'h1);
    end
    rd(`CAPB_OFS);
    check(v, 32'h0);
    $display("edge test done");
  endtask : t_edges

  task automatic t_period;
    // restart from zero so the match is reached without a full wrap
    wr(`CTRL_OFS, 32'h2);
    wr(`PERIOD_OFS, 32'h5);
    wr(`CTRL_OFS, ctl(0, 0, 0));
    wr(`STATUS_OFS, 32'h3);
    repeat (40) @(posedge clk);
    rd(`STATUS_OFS);
    check(v & 32'h2, 32'h2);
    rd(`COUNT_OFS);
    check({31'h0, v <= 32'h5}, 32'h1);
    wr(`PERIOD_OFS, 32'h0);
    repeat (40) @(posedge clk);
    rd(`COUNT_OFS);
    check({31'h0, v > 32'h5}, 32'h1);
    $display("period test done");
  endtask : t_period

  task automatic t_clear;
    for (int c = 1; c < 4; c++)
    begin
      wr(`CTRL_OFS, 32'h2);
      wr(`CTRL_OFS, ctl(2, c, 0));
      repeat (100) @(posedge clk);
      src.drive(0, 1'b1, 20);
      rd(`STATUS_OFS);
      check(v & 32'h4, 32'h4);
      src.drive(0, 1'b0, 20);
      rd(`STATUS_OFS);
      check(v & 32'h4, 32'h0);
      rd(`CAPB_OFS);
      // a rising clear leaves only the high phase in the second register
      check({31'h0, v < 32'd40 && v != 0}, {31'h0, c[0]});
    end
    $display("clear test done");
  endtask : t_clear

  task automatic t_pinclk;
    wr(`CTRL_OFS, 32'h2);
    wr(`CTRL_OFS, ctl(0, 0, 0) | 32'h200);
    wr(`STATUS_OFS, 32'h3);
    for (int i = 0; i < 10; i++)
    begin
      src.drive(1, 1'b1, 4);
      src.drive(1, 1'b0, 4);
    end
    rd(`COUNT_OFS);
    check(v, 32'd10);
    src.drive(0, 1'b1, 4);
    for (int i = 0; i < 2; i++)
    begin
      src.drive(1, 1'b1, 4);
      src.drive(1, 1'b0, 4);
    end
    rd(`CAPA_OFS);
    check(v, 32'd10);
    rd(`STATUS_OFS);
    check(v & 32'h1, 32'h1);
    src.drive(0, 1'b0, 4);
    $display("pin clock test done");
  endtask : t_pinclk

  task automatic t_run;
    wr(`CTRL_OFS, 32'h2);
    rd(`COUNT_OFS);
    c0 = v;
    repeat (20) @(posedge clk);
    rd(`COUNT_OFS);
    check(v, c0);
    wr(`CTRL_OFS, ctl(0, 0, 0));
    rd(`COUNT_OFS);
    check({31'h0, v < 32'd8}, 32'h1);
    check({30'h0, t_out, t_oe_n}, 32'h1);
    $display("run test done");
  endtask : t_run

  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset;
    t_sources;
    t_edges;
    t_period;
    t_clear;
    t_pinclk;
    t_run;
    results;
  end

  // whole run takes little more than a thousand cycles
  initial
  begin
    #200000;
    err_count++;
    results;
  end
endmodule : tb
`default_nettype wire
